// >>> include/spi_gpio_expander_pkg.sv
/*
 * Constants for the 14-bit port expander core: register offsets, reset
 * values, bank layout and debounce timing.
 * Assumes a single 10 MHz clock domain and a 32-bit AHB-Lite register bus
 * on which each register takes one aligned word.
 */
// Overview of operation
// - fourteen bidirectional port bits, bank 0 eight bits, bank 1 six bits.
// - after power-on every port bit is an input.
// - per-bit direction bits written by host set each pin's direction.
// - input register holds sampled pins, output register holds driven values.
// - per-bit polarity setting inverts the reported input value.
// - power-on reset defaults all registers and the interface state.
// - reset pin low gives the same defaulting as power-on.
// - interrupt request asserts while any input differs from its stored state.
// - latched bits keep the value that caused an interrupt until input read; here a clear write also releases a bit not set to edge.
// - per-bit mask stops an input change raising the request.
// - read-only status register shows which bits have pending interrupts.
// - each bit's interrupt is programmable as level or edge sensitive.
// - host clears any single pending bit without touching the others.
// - reading pending events does not clear them.
// - each output bit has a four-level drive strength setting.
// - each bank selects push-pull or open-drain output stages.
// - per-bit pull resistor enable; disabled leaves the input floating.
// - with pull enabled a per-bit select chooses up or down.
// - debounce logic filters changes on the input pins.
// - address strap pin selects which serial bus address is answered; here it only sets bit 1 of the read-only bus address register.
package spi_gpio_expander_pkg;
    localparam int NUM_BITS   = 14;
    localparam int BANK0_BITS = 8;
    localparam int BANK1_BITS = 6;

    // register byte offsets
    localparam logic [7:0] OFS_INPUT     = 8'h00;
    localparam logic [7:0] OFS_OUTPUT    = 8'h04;
    localparam logic [7:0] OFS_POLARITY  = 8'h08;
    localparam logic [7:0] OFS_DIRECTION = 8'h0C;
    localparam logic [7:0] OFS_DRIVE     = 8'h10;
    localparam logic [7:0] OFS_PULL_EN   = 8'h14;
    localparam logic [7:0] OFS_PULL_SEL  = 8'h18;
    localparam logic [7:0] OFS_LATCH_EN  = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;
    localparam logic [7:0] OFS_IRQ_EDGE  = 8'h24;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h2C;
    localparam logic [7:0] OFS_OUT_STAGE = 8'h30;
    localparam logic [7:0] OFS_DEB_EN    = 8'h34;
    localparam logic [7:0] OFS_BUS_ADDR  = 8'h38;

    // values after reset
    localparam logic [13:0] OUTPUT_RST    = 14'h3FFF;
    localparam logic [13:0] POLARITY_RST  = 14'h0000;
    localparam logic [13:0] DIRECTION_RST = 14'h3FFF;
    localparam logic [27:0] DRIVE_RST     = 28'hFFFFFFF;
    localparam logic [13:0] PULL_EN_RST   = 14'h0000;
    localparam logic [13:0] PULL_SEL_RST  = 14'h3FFF;
    localparam logic [13:0] LATCH_EN_RST  = 14'h0000;
    localparam logic [13:0] IRQ_MASK_RST  = 14'h3FFF;
    localparam logic [13:0] IRQ_EDGE_RST  = 14'h0000;
    localparam logic [1:0]  OUT_STAGE_RST = 2'h0;
    localparam logic [13:0] DEB_EN_RST    = 14'h0000;

    // serial bus address: base, strap moves bit 1
    localparam logic [7:0] BUS_ADDR_BASE  = 8'h40;
    localparam int         BUS_ADDR_STRAP = 1;

    // debounce sampling interval
    localparam int DEB_TIME_US     = 1000;
    localparam int CLK_FREQ_MHZ    = 10;
    localparam int DEB_CYCLES_DEF  = DEB_TIME_US * CLK_FREQ_MHZ;
    localparam int DEB_CNT_W       = 16;
endpackage : spi_gpio_expander_pkg

// >>> testbench/pad_world_model.sv
/*
 * Pad model for the expander's port pins: resolves drive, pulls and an
 * external source per bit. Assumes the core's pin_out/pin_oe/pull ports.
 */
`timescale 1ns/1ps
`default_nettype none

module pad_world_model (
    input  wire logic [13:0] pin_out,  // core drive value
    input  wire logic [13:0] pin_oe,   // core drive enable
    input  wire logic [13:0] pull_en,  // pull enable
    input  wire logic [13:0] pull_up,  // pull direction
    input  wire logic [13:0] ext,      // external source level
    output logic      [13:0] pin_in    // resolved pad level
);
    // driver beats pull; with no pull the far side sets the level
    always_comb begin
        for (int i = 0; i < 14; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (pull_en[i] ? pull_up[i] : ext[i]);
        end
    end
endmodule : pad_world_model
`default_nettype wire

// >>> testbench/spi_gpio_expander_core_test.sv
/*
 * Self-checking bench for the expander core: register bus, pins, interrupt.
 * Assumes the core answers with no wait states and debounce off by default.
 */
`timescale 1ns/1ps
`default_nettype none

module spi_gpio_expander_core_test;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, strap = 0, hrdy, hresp, irq_oe, irq_o;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q, x, d;
    logic [1:0]  htrans = 0;
    logic [13:0] pin_in, pin_out, pin_oe, pull_en, pull_up, ext = 0;
    logic [27:0] drv;
    int seed = 13, num_errors = 0, n_checks = 0;

    always #50 hclk = ~hclk;

    spi_gpio_expander_core #(.DEB_CYCLES(4)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
        .pull_up(pull_up), .drive_sel(drv), .addr_strap(strap), .irq_n_out(irq_o),
        .irq_n_oe(irq_oe));
    pad_world_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
        .pull_up(pull_up), .ext(ext), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////
    // one single transfer; master waits for ready in both phases
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a};
        @(posedge hclk);
        while (hrdy !== 1'b1) @(posedge hclk);
        hsel <= 0; htrans <= 2'h0; hwdata <= wd;
        @(posedge hclk);
        while (hrdy !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : bus
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task results;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task settle;
        repeat (8) @(posedge hclk);
    endtask : settle

    // watchdog: the whole sequence needs well under this many cycles
    initial begin
        repeat (6000) @(posedge hclk);
        num_errors++;
        results;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        bus(0, 8'h0C, 0); chk(q, 32'h00003FFF);
        chk(pin_oe, 14'h0000);
        chk(drv, 28'hFFFFFFF);
        bus(0, 8'h38, 0); chk(q, 32'h00000040);
        // random direction/output mixes, push-pull then open-drain
        for (int i = 0; i < 4; i++) begin
            d = $random(seed) & 32'h3FFF; x = $random(seed) & 32'h3FFF;
            bus(1, 8'h04, x); bus(1, 8'h0C, d); bus(1, 8'h30, i / 2 * 3);
            settle;
            if (i < 2) chk(pin_oe, {18'h0, ~d[13:0]});
            if (i < 2) chk(pin_out & ~d[13:0], x[13:0] & ~d[13:0]);
            if (i >= 2) chk(pin_oe, {18'h0, ~d[13:0] & ~x[13:0]});
            x = $random(seed); bus(1, 8'h10, x); settle; chk(drv, x[27:0]);
        end
        bus(1, 8'h30, 0); bus(1, 8'h0C, 32'h3FFF);
        x = $random(seed); d = $random(seed);
        bus(1, 8'h14, x); bus(1, 8'h18, d); settle;
        chk(pull_en, x[13:0]);
        chk(pull_up, d[13:0]);
        bus(1, 8'h14, 0); ext <= x[13:0]; bus(1, 8'h08, d); settle;
        bus(0, 8'h00, 0); chk(q, {18'h0, x[13:0] ^ d[13:0]});
        // bit0 level, bit1 edge, bit2 latched, rest masked
        bus(1, 8'h08, 0); bus(1, 8'h20, 32'h3FF8); bus(1, 8'h24, 2);
        bus(1, 8'h1C, 4); bus(0, 8'h00, 0); settle; x = ext;
        ext <= ext ^ 14'h0027; settle;
        chk(irq_oe, 1'b1);
        ext[5] <= x[5]; ext[2] <= x[2];
        bus(0, 8'h2C, 0); chk(q, 32'h00000007);
        bus(0, 8'h2C, 0); chk(q, 32'h00000007);
        bus(1, 8'h28, 2); bus(0, 8'h2C, 0); chk(q, 32'h00000005);
        ext[0] <= x[0]; settle;
        bus(0, 8'h2C, 0); chk(q, 32'h00000004);
        bus(0, 8'h00, 0); chk(q[2], !x[2]);
        // the read re-arms bit 2 against its held value; a second read settles it
        bus(0, 8'h00, 0); bus(0, 8'h2C, 0); chk(q, 32'h00000000);
        chk(irq_oe, 1'b0);
        // debounce on: a one-cycle glitch on the latched bit is filtered out
        bus(1, 8'h34, 32'h3FFF); ext[2] <= !x[2]; @(posedge hclk); ext[2] <= x[2]; settle;
        bus(0, 8'h2C, 0); chk(q, 32'h00000000);
        ext[2] <= !x[2]; settle; settle;
        bus(0, 8'h2C, 0); chk(q, 32'h00000004);
        // reset in mid-run must restore defaults and catch the strap again
        bus(1, 8'h0C, 0); strap <= 1; hresetn <= 0; settle; hresetn <= 1;
        bus(0, 8'h0C, 0); chk(q, 32'h00003FFF);
        bus(0, 8'h38, 0); chk(q, 32'h00000042);
        results;
    end
endmodule : spi_gpio_expander_core_test
`default_nettype wire

// >>> verilog/spi_gpio_expander_core.sv
/*
 * Port logic of a 14-bit I/O expander behind an AHB-Lite register slave:
 * direction, output latch, polarity, input latching, pulls, drive strength,
 * output stage per bank, debounce and a maskable open-drain interrupt.
 * Assumes pins and the address strap arrive asynchronously; pad drivers
 * resolve pin_out/pin_oe and the open-drain request outside this block.
 */
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module spi_gpio_expander_core #(
    parameter int DEB_CYCLES = spi_gpio_expander_pkg::DEB_CYCLES_DEF
) (
    input  wire logic        hclk,        // bus clock, 10 MHz
    input  wire logic        hresetn,     // async reset, active low
    input  wire logic        hsel,        // slave select
    input  wire logic [31:0] haddr,       // byte address
    input  wire logic [1:0]  htrans,      // transfer type
    input  wire logic        hwrite,      // write when high
    input  wire logic [2:0]  hsize,       // transfer size, word only
    input  wire logic [31:0] hwdata,      // write data
    input  wire logic        hready,      // bus ready
    output logic      [31:0] hrdata,      // read data
    output logic             hreadyout,   // slave ready
    output logic             hresp,       // always okay
    input  wire logic [13:0] pin_in,      // pad levels, bank 1 in [13:8]
    output logic      [13:0] pin_out,     // pad drive value
    output logic      [13:0] pin_oe,      // pad drive enable
    output logic      [13:0] pull_en,     // pull resistor enable
    output logic      [13:0] pull_up,     // 1 pull up, 0 pull down
    output logic      [27:0] drive_sel,   // two bits per pin
    input  wire logic        addr_strap,  // address strap level
    output logic             irq_n_out,   // request pad value, always low
    output logic             irq_n_oe     // high while request is pulled low
);

    ////////////////////////////////////////////////////////////////////////
    // decode helper

    // true when a word offset hits the given register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [13:0] sync1_r, sync2_r;            // pin synchroniser
    logic        strap1_r, strap2_r;          // strap synchroniser
    // counter width alias; nothing is imported from the package
    localparam int CNT_W = spi_gpio_expander_pkg::DEB_CNT_W;

    logic        caught_r, caught_nxt;
    logic        strap_wait_r, strap_wait_nxt;   // strap synchroniser has filled
    logic [7:0]  bus_addr_r, bus_addr_nxt;
    logic [CNT_W-1:0] tick_cnt_r, tick_cnt_nxt;
    logic [13:0] smp_r, smp_nxt;
    logic [13:0] deb_r, deb_nxt;
    logic [13:0] prev_r, prev_nxt;
    logic [13:0] out_r, out_nxt;
    logic [13:0] pol_r, pol_nxt;
    logic [13:0] dir_r, dir_nxt;
    logic [27:0] drive_r, drive_nxt;
    logic [13:0] pen_r, pen_nxt;
    logic [13:0] psel_r, psel_nxt;
    logic [13:0] latch_r, latch_nxt;
    logic [13:0] mask_r, mask_nxt;
    logic [13:0] edge_r, edge_nxt;
    logic [1:0]  stage_r, stage_nxt;
    logic [13:0] deben_r, deben_nxt;
    logic [13:0] snap_r, snap_nxt;
    logic [13:0] hold_r, hold_nxt;
    logic [13:0] held_r, held_nxt;
    logic [13:0] pend_r, pend_nxt;
    logic        wpend_r, wpend_nxt;
    logic [7:0]  waddr_r, waddr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [13:0] pout_r, pout_nxt;
    logic [13:0] poe_r, poe_nxt;
    logic        irq_r, irq_nxt;
    logic        rst_done_r;

    logic        take, rd_take, rd_input;
    logic [7:0]  ra;
    logic [13:0] raw_rd, differ, clr, edge_ev, level_st, status;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers: first stage feeds only the second

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r  <= 14'h0000;
            sync2_r  <= 14'h0000;
            strap1_r <= 1'b0;
            strap2_r <= 1'b0;
        end else begin
            sync1_r  <= pin_in;
            sync2_r  <= sync1_r;
            strap1_r <= addr_strap;
            strap2_r <= strap1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus address phase decode, zero wait state

    assign take     = hsel & htrans[1] & hready;
    assign rd_take  = take & ~hwrite;
    assign ra       = {haddr[7:2], 2'b00};
    assign rd_input = rd_take & hit(ra, spi_gpio_expander_pkg::OFS_INPUT);
    assign clr      = (wpend_r & hit(waddr_r, spi_gpio_expander_pkg::OFS_IRQ_CLEAR))
                      ? hwdata[13:0] : 14'h0000;

    ////////////////////////////////////////////////////////////////////////
    // input path and interrupt status (combinational view)

    always_comb begin
        raw_rd   = (hold_r & latch_r & held_r) | (~(hold_r & latch_r) & deb_r);
        differ   = deb_r ^ snap_r;
        edge_ev  = (deb_r ^ prev_r) & edge_r & ~mask_r;
        level_st = (differ | hold_r) & ~edge_r & ~mask_r;
        status   = level_st | pend_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: debounce, latching, pending bits, strap capture

    always_comb begin
        // debounce samples on a slow tick; the sample must agree twice, so
        // contact bounce shorter than one interval never reaches the logic
        tick_cnt_nxt = tick_cnt_r + 1'b1;
        smp_nxt      = smp_r;
        deb_nxt      = (deb_r & deben_r) | (sync2_r & ~deben_r);
        if (tick_cnt_r == CNT_W'(DEB_CYCLES - 1)) begin
            tick_cnt_nxt = '0;
            smp_nxt      = sync2_r;
            deb_nxt      = ((~(sync2_r ^ smp_r) & sync2_r) |
                            ((sync2_r ^ smp_r) & deb_r)) & deben_r |
                           (sync2_r & ~deben_r);
        end
        prev_nxt = deb_r;

        // latched bits freeze on the first change; reading releases them
        hold_nxt = hold_r;
        held_nxt = held_r;
        snap_nxt = snap_r;
        for (int i = 0; i < spi_gpio_expander_pkg::NUM_BITS; i++) begin
            if (rd_input) begin
                hold_nxt[i] = 1'b0;
                snap_nxt[i] = raw_rd[i];
            end else if (clr[i] && !edge_r[i]) begin
                hold_nxt[i] = 1'b0;
                snap_nxt[i] = deb_r[i];
            end else if (latch_r[i] && differ[i] && !hold_r[i]) begin
                hold_nxt[i] = 1'b1;
                held_nxt[i] = deb_r[i];
            end
        end

        // edge events are sticky; a new edge wins over a clear
        pend_nxt = (pend_r & ~clr) | edge_ev;
        irq_nxt  = |status;

        // strap follows its synchroniser until that holds a real sample
        // (two edges after release), then freezes at the third edge;
        // catching it earlier would only ever see the flops' reset value
        strap_wait_nxt = rst_done_r;
        caught_nxt     = strap_wait_r;
        bus_addr_nxt   = bus_addr_r;
        if (!caught_r) begin
            bus_addr_nxt = spi_gpio_expander_pkg::BUS_ADDR_BASE |
                           (8'(strap2_r) << spi_gpio_expander_pkg::BUS_ADDR_STRAP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: register writes (data phase) and read data (address phase)

    always_comb begin
        wpend_nxt = take & hwrite;
        waddr_nxt = ra;
        out_nxt   = out_r;
        pol_nxt   = pol_r;
        dir_nxt   = dir_r;
        drive_nxt = drive_r;
        pen_nxt   = pen_r;
        psel_nxt  = psel_r;
        latch_nxt = latch_r;
        mask_nxt  = mask_r;
        edge_nxt  = edge_r;
        stage_nxt = stage_r;
        deben_nxt = deben_r;
        if (wpend_r) begin
            case (waddr_r)
                spi_gpio_expander_pkg::OFS_OUTPUT:    out_nxt   = hwdata[13:0];
                spi_gpio_expander_pkg::OFS_POLARITY:  pol_nxt   = hwdata[13:0];
                spi_gpio_expander_pkg::OFS_DIRECTION: dir_nxt   = hwdata[13:0];
                spi_gpio_expander_pkg::OFS_DRIVE:     drive_nxt = hwdata[27:0];
                spi_gpio_expander_pkg::OFS_PULL_EN:   pen_nxt   = hwdata[13:0];
                spi_gpio_expander_pkg::OFS_PULL_SEL:  psel_nxt  = hwdata[13:0];
                spi_gpio_expander_pkg::OFS_LATCH_EN:  latch_nxt = hwdata[13:0];
                spi_gpio_expander_pkg::OFS_IRQ_MASK:  mask_nxt  = hwdata[13:0];
                spi_gpio_expander_pkg::OFS_IRQ_EDGE:  edge_nxt  = hwdata[13:0];
                spi_gpio_expander_pkg::OFS_OUT_STAGE: stage_nxt = hwdata[1:0];
                spi_gpio_expander_pkg::OFS_DEB_EN:    deben_nxt = hwdata[13:0];
                default: ;
            endcase
        end

        // read data is registered here and stands in the data phase;
        // a write still in its data phase is not yet visible
        rdata_nxt = 32'h00000000;
        if (rd_take) begin
            case (ra)
                spi_gpio_expander_pkg::OFS_INPUT:     rdata_nxt = {18'h00000, raw_rd ^ pol_r};
                spi_gpio_expander_pkg::OFS_OUTPUT:    rdata_nxt = {18'h00000, out_r};
                spi_gpio_expander_pkg::OFS_POLARITY:  rdata_nxt = {18'h00000, pol_r};
                spi_gpio_expander_pkg::OFS_DIRECTION: rdata_nxt = {18'h00000, dir_r};
                spi_gpio_expander_pkg::OFS_DRIVE:     rdata_nxt = {4'h0, drive_r};
                spi_gpio_expander_pkg::OFS_PULL_EN:   rdata_nxt = {18'h00000, pen_r};
                spi_gpio_expander_pkg::OFS_PULL_SEL:  rdata_nxt = {18'h00000, psel_r};
                spi_gpio_expander_pkg::OFS_LATCH_EN:  rdata_nxt = {18'h00000, latch_r};
                spi_gpio_expander_pkg::OFS_IRQ_MASK:  rdata_nxt = {18'h00000, mask_r};
                spi_gpio_expander_pkg::OFS_IRQ_EDGE:  rdata_nxt = {18'h00000, edge_r};
                spi_gpio_expander_pkg::OFS_IRQ_STAT:  rdata_nxt = {18'h00000, status};
                spi_gpio_expander_pkg::OFS_OUT_STAGE: rdata_nxt = {30'h00000000, stage_r};
                spi_gpio_expander_pkg::OFS_DEB_EN:    rdata_nxt = {18'h00000, deben_r};
                spi_gpio_expander_pkg::OFS_BUS_ADDR:  rdata_nxt = {24'h000000, bus_addr_r};
                default:                              rdata_nxt = 32'h00000000;
            endcase
        end

        // pad drive: direction bit 1 = input; open-drain only drives low
        for (int i = 0; i < spi_gpio_expander_pkg::NUM_BITS; i++) begin
            if (stage_r[i >= spi_gpio_expander_pkg::BANK0_BITS]) begin
                pout_nxt[i] = 1'b0;
                poe_nxt[i]  = ~dir_r[i] & ~out_r[i];
            end else begin
                pout_nxt[i] = out_r[i];
                poe_nxt[i]  = ~dir_r[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers: one reset serves power-on and the reset pin alike

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            caught_r   <= 1'b0;
            strap_wait_r <= 1'b0;
            bus_addr_r <= spi_gpio_expander_pkg::BUS_ADDR_BASE;
            tick_cnt_r <= '0;
            smp_r      <= 14'h0000;
            deb_r      <= 14'h0000;
            prev_r     <= 14'h0000;
            out_r      <= spi_gpio_expander_pkg::OUTPUT_RST;
            pol_r      <= spi_gpio_expander_pkg::POLARITY_RST;
            dir_r      <= spi_gpio_expander_pkg::DIRECTION_RST;
            drive_r    <= spi_gpio_expander_pkg::DRIVE_RST;
            pen_r      <= spi_gpio_expander_pkg::PULL_EN_RST;
            psel_r     <= spi_gpio_expander_pkg::PULL_SEL_RST;
            latch_r    <= spi_gpio_expander_pkg::LATCH_EN_RST;
            mask_r     <= spi_gpio_expander_pkg::IRQ_MASK_RST;
            edge_r     <= spi_gpio_expander_pkg::IRQ_EDGE_RST;
            stage_r    <= spi_gpio_expander_pkg::OUT_STAGE_RST;
            deben_r    <= spi_gpio_expander_pkg::DEB_EN_RST;
            snap_r     <= 14'h0000;
            hold_r     <= 14'h0000;
            held_r     <= 14'h0000;
            pend_r     <= 14'h0000;
            wpend_r    <= 1'b0;
            waddr_r    <= 8'h00;
            rdata_r    <= 32'h00000000;
            pout_r     <= 14'h0000;
            poe_r      <= 14'h0000;
            irq_r      <= 1'b0;
            rst_done_r <= 1'b0;
        end else begin
            caught_r   <= caught_nxt;
            strap_wait_r <= strap_wait_nxt;
            bus_addr_r <= bus_addr_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            smp_r      <= smp_nxt;
            deb_r      <= deb_nxt;
            prev_r     <= prev_nxt;
            out_r      <= out_nxt;
            pol_r      <= pol_nxt;
            dir_r      <= dir_nxt;
            drive_r    <= drive_nxt;
            pen_r      <= pen_nxt;
            psel_r     <= psel_nxt;
            latch_r    <= latch_nxt;
            mask_r     <= mask_nxt;
            edge_r     <= edge_nxt;
            stage_r    <= stage_nxt;
            deben_r    <= deben_nxt;
            snap_r     <= snap_nxt;
            hold_r     <= hold_nxt;
            held_r     <= held_nxt;
            pend_r     <= pend_nxt;
            wpend_r    <= wpend_nxt;
            waddr_r    <= waddr_nxt;
            rdata_r    <= rdata_nxt;
            pout_r     <= pout_nxt;
            poe_r      <= poe_nxt;
            irq_r      <= irq_nxt;
            rst_done_r <= 1'b1;
        end
    end

    // outputs from flip-flops or tied constants; no wait states, no error answers
    assign hrdata    = rdata_r;
    assign hreadyout = rst_done_r | ~rst_done_r;
    assign hresp     = 1'b0 & rst_done_r;
    assign pin_out   = pout_r;
    assign pin_oe    = poe_r;
    assign pull_en   = pen_r;
    assign pull_up   = psel_r;
    assign drive_sel = drive_r;
    assign irq_n_out = 1'b0 & irq_r;
    assign irq_n_oe  = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_irq_follows_status: assert property (|status |=> irq_n_oe)
        else $error("request not raised for pending status");
    a_irq_idle_quiet: assert property (status == 14'h0000 |=> !irq_n_oe)
        else $error("request raised with no pending status");
    a_mask_blocks_all: assert property (
        (mask_r == 14'h3FFF && pend_r == 14'h0000) |=> !irq_n_oe)
        else $error("masked inputs raised the request");
    a_dir_input_float: assert property (
        (dir_r == 14'h3FFF) |=> (pin_oe == 14'h0000))
        else $error("input-configured pin is driven");
    a_first_cycle_input: assert property (
        !rst_done_r |-> (dir_r == 14'h3FFF && pend_r == 14'h0000))
        else $error("registers not at defaults after reset");
    a_polarity_read: assert property (
        rd_input |=> (hrdata[13:0] == $past(raw_rd ^ pol_r)))
        else $error("input read ignores polarity");
    a_latch_holds: assert property (
        (!rd_input && clr == 14'h0000) |=> ((hold_r & $past(hold_r)) == $past(hold_r)))
        else $error("latched bit released without a read");
    a_status_read_keeps: assert property (
        (rd_take && ra == spi_gpio_expander_pkg::OFS_IRQ_STAT && clr == 14'h0000)
        |=> ((pend_r & $past(pend_r)) == $past(pend_r)))
        else $error("status read cleared pending events");
    a_clear_only_chosen: assert property (
        (clr != 14'h0000) |=> ((pend_r & ~$past(clr)) ==
                               (($past(pend_r) | $past(edge_ev)) & ~$past(clr))))
        else $error("clear disturbed other pending bits");
    a_clear_takes_effect: assert property (
        (clr != 14'h0000 && edge_ev == 14'h0000) |=> ((pend_r & $past(clr)) == 14'h0000))
        else $error("pending bit survived its clear");
    a_open_drain_low: assert property (
        stage_r == 2'h3 |=> ((pin_oe & pin_out) == 14'h0000))
        else $error("open-drain stage drove high");
    a_strap_address: assert property (
        caught_r |-> (bus_addr_r == 8'h40 || bus_addr_r == 8'h42))
        else $error("bus address outside strap choices");

    c_irq_raised:   cover property (!irq_n_oe ##1 irq_n_oe);
    c_latched_read: cover property (|(hold_r & latch_r) ##[1:50] rd_input);
    c_single_clear: cover property ((pend_r != 14'h0000) ##1 (clr != 14'h0000));
    c_edge_event:   cover property (edge_ev != 14'h0000);

endmodule : spi_gpio_expander_core

`default_nettype wire
